/* verilog/fault_irq_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef FAULT_IRQ_DEFS_SVH
`define FAULT_IRQ_DEFS_SVH
`define ADDR_RATIO_HIGH 8'h40
`define ADDR_RATIO_LOW 8'h41
`define ADDR_INT_CFG 8'h42
`define ADDR_OUT_FLT_CFG 8'h43
`define INT_CFG_RESET 8'h00
`define OUT_FLT_CFG_RESET 8'h54
`define IRQ_POLARITY_BIT 7
`define INT_EVT_HI 6
`define INT_EVT_LO 5
`define CH_POL_HI 4
`define CH_POL_LO 3
`define RD_FILT_BIT 2
`define CH_RCV_BIT 1
`define CLR_POL_BIT 0
`define OUT_POL_HI 6
`define OUT_POL_LO 5
`define OUT_RCV_BIT 4
`define OUT_STS_BIT 3
`define GUARD_IGN_BIT 2
`define OUT_DET_OFF_BIT 1
`define REG_DET_OFF_BIT 0
`define CLK_MHZ 125
`define PULSE_US 2000
`define PERIOD_US 4000
`define PULSE_CYC (`PULSE_US * `CLK_MHZ)
`define PERIOD_CYC (`PERIOD_US * `CLK_MHZ)
`endif

/* verilog/fault_irq_pkg.sv */
// types shared by the fault and interrupt control logic
package fault_irq_pkg;
   typedef enum logic [1:0]
   {
      EVT_LATCHED = 2'h0,
      EVT_LIVE = 2'h1,
      EVT_REPEAT = 2'h2,
      EVT_SINGLE = 2'h3
   } irq_mode_e;
   typedef enum logic [1:0]
   {
      PD_IGNORE = 2'h0,
      PD_UNMASKED = 2'h1,
      PD_ALL = 2'h2,
      PD_RESERVED = 2'h3
   } pd_policy_e;
   typedef enum logic [1:0]
   {
      PG_IDLE = 2'h0,
      PG_HIGH = 2'h1,
      PG_LOW = 2'h3
   } pulse_state_e;
endpackage

/* verilog/fault_powerdown.sv */
// per-channel fault power-down holder with auto or manual recovery
`timescale 1ns/1ps
module fault_powerdown #(
   parameter int CH = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // policy and faults
   input wire fault_irq_pkg::pd_policy_e policy,
   input wire logic manual_rcv,
   input wire logic [CH-1:0] fault,
   input wire logic [CH-1:0] mask,
   input wire logic [CH-1:0] release_req,
   // held power-down per channel
   output logic [CH-1:0] pd
);
   import fault_irq_pkg::*;
   logic [CH-1:0] pd_q;
   logic [CH-1:0] pd_d;
   wire logic [CH-1:0] hit;
   // choose which faults count for power-down
   assign hit = (policy == PD_ALL) ? fault :
                (policy == PD_UNMASKED) ? (fault & ~mask) : '0;
   // hold until fault gone (auto) or gone and released (manual)
   assign pd_d = hit | (pd_q & (manual_rcv ? ~release_req : fault));
   assign pd = pd_q;
   // power-down register
   always_ff @(posedge clk)
   begin
      if (rst)
         pd_q <= '0;
      else
         pd_q <= pd_d;
   end
endmodule

/* verilog/fault_interrupt_control.sv */
// interrupt pin, latched event store and fault power-down configuration
//
// Overview of operation
// - pin polarity follows config bit 7
// - mode 0 latched, mode 1 live events
// - mode 2 pulses 2 ms every 4 ms
// - mode 3 one 2 ms pulse per event
// - channel power-down policy in bits 4-3
// - readback filter shows unmasked bits only
// - input channel recovery auto or manual
// - read clears bit only if live clear
// - bit 0 set: read clears latched bits unconditionally
// - output policy bits 6-5, reset 10b
// - output recovery bit 4, reset manual
// - status bit 3 shows output held down
// - bit 2 ignores guard fault at power-up
// - bit 1 disables output fault detection
// - bit 0 disables regulator short detection
// - 0x41 reads ratio low byte
// - 0x40 bits 5-0 read ratio high
`timescale 1ns/1ps
`include "fault_irq_defs.svh"
module fault_interrupt_control #(
   parameter int NEV = 8,
   parameter int NIN = 4,
   parameter int NOUT = 2,
   parameter int PULSE_CYCLES = `PULSE_CYC,
   parameter int PERIOD_CYCLES = `PERIOD_CYC
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // register access port
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   // latched event store access
   input wire logic LATCH_RD,
   output logic [NEV-1:0] LATCH_RDATA,
   // events and their mask
   input wire logic [NEV-1:0] EVENT_LIVE,
   input wire logic [NEV-1:0] EVENT_MASK,
   // detected frame-sync to clock-source ratio
   input wire logic [13:0] FRAME_CLOCK_RATIO,
   // input channel and bias faults
   input wire logic [NIN-1:0] IN_FAULT,
   input wire logic [NIN-1:0] IN_FAULT_MASK,
   input wire logic [NIN-1:0] IN_RELEASE,
   output logic [NIN-1:0] IN_POWER_DOWN,
   // output converter faults
   input wire logic [NOUT-1:0] OUT_GUARD_FAULT,
   input wire logic [NOUT-1:0] OUT_SHORT_FAULT,
   input wire logic [NOUT-1:0] OUT_POWERING_UP,
   input wire logic [NOUT-1:0] OUT_FAULT_MASK,
   input wire logic [NOUT-1:0] OUT_RELEASE,
   output logic [NOUT-1:0] OUT_POWER_DOWN,
   // regulator short detection
   input wire logic REG_SHORT_RAW,
   output logic REG_SHORT_FAULT,
   // interrupt pin
   output logic IRQ_PIN
);
   import fault_irq_pkg::*;

   // ==========================================================
   // configuration registers
   logic [7:0] int_cfg_q;
   logic [6:0] out_cfg_q;
   logic [NEV-1:0] latch_q;
   logic [NEV-1:0] live_q;
   logic [NEV-1:0] latch_d;
   pulse_state_e pg_state_q;
   pulse_state_e pg_state_d;
   logic [31:0] pg_cnt_q;
   logic [31:0] pg_cnt_d;
   logic [13:0] ratio_q;
   logic [NOUT-1:0] out_guard_q;
   logic [NOUT-1:0] out_short_q;

   wire logic irq_polarity = int_cfg_q[`IRQ_POLARITY_BIT];
   wire irq_mode_e irq_mode = irq_mode_e'(int_cfg_q[`INT_EVT_HI:`INT_EVT_LO]);
   wire pd_policy_e chan_fault_powerdown_policy =
      pd_policy_e'(int_cfg_q[`CH_POL_HI:`CH_POL_LO]);
   wire logic latched_readback_filter = int_cfg_q[`RD_FILT_BIT];
   wire logic chan_fault_recovery_mode = int_cfg_q[`CH_RCV_BIT];
   wire logic latched_clear_policy = int_cfg_q[`CLR_POL_BIT];
   wire pd_policy_e out_fault_powerdown_policy =
      pd_policy_e'(out_cfg_q[`OUT_POL_HI:`OUT_POL_LO]);
   wire logic out_fault_recovery_mode = out_cfg_q[`OUT_RCV_BIT];
   wire logic guard_fault_ignore_on_powerup = out_cfg_q[`GUARD_IGN_BIT];
   wire logic out_fault_detect_off = out_cfg_q[`OUT_DET_OFF_BIT];
   wire logic regulator_short_detect_off = out_cfg_q[`REG_DET_OFF_BIT];

   wire logic wr_int = REG_WR && (REG_ADDR == `ADDR_INT_CFG);
   wire logic wr_out = REG_WR && (REG_ADDR == `ADDR_OUT_FLT_CFG);

   // register writes; bit 7 and status bit 3 of output config are not stored
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         int_cfg_q <= `INT_CFG_RESET;
         out_cfg_q <= 7'(`OUT_FLT_CFG_RESET);
      end
      else
      begin
         if (wr_int)
            int_cfg_q <= REG_WDATA;
         if (wr_out)
            out_cfg_q <= {REG_WDATA[6:4], 1'b0, REG_WDATA[2:0]};
      end
   end

   // ==========================================================
   // input synchronisers for asynchronous sources
   logic [NEV-1:0] live_s1;
   logic [13:0] ratio_s1;
   logic [13:0] ratio_s2;
   logic [13:0] ratio_s3;
   logic [NOUT-1:0] guard_s1;
   logic [NOUT-1:0] short_s1;
   logic reg_short_s1;
   logic reg_short_q;

   // two-stage sync of events, faults and ratio
   always_ff @(posedge CLK_SYS)
   begin
      live_s1 <= EVENT_LIVE;
      live_q <= live_s1;
      ratio_s1 <= FRAME_CLOCK_RATIO;
      ratio_s2 <= ratio_s1;
      ratio_s3 <= ratio_s2;
      // a multi-bit word: take it only once two synced samples agree
      if (ratio_s2 == ratio_s3)
         ratio_q <= ratio_s2;
      guard_s1 <= OUT_GUARD_FAULT;
      out_guard_q <= guard_s1;
      short_s1 <= OUT_SHORT_FAULT;
      out_short_q <= short_s1;
      reg_short_s1 <= REG_SHORT_RAW;
      reg_short_q <= reg_short_s1;
   end

   // ==========================================================
   // latched event store
   logic [NEV-1:0] live_prev_q;
   wire logic [NEV-1:0] rise = live_q & ~live_prev_q;
   wire logic [NEV-1:0] unmasked_latch = latch_q & ~EVENT_MASK;
   wire logic [NEV-1:0] clr_mask =
      latched_clear_policy ? {NEV{1'b1}} : ~live_q;
   wire logic [NEV-1:0] clr = LATCH_RD ? clr_mask : '0;

   // set wins over a clear in the same cycle
   assign latch_d = rise | (latch_q & ~clr);
   assign LATCH_RDATA = latched_readback_filter ? unmasked_latch : latch_q;

   // latched bits and edge detect
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         latch_q <= '0;
         live_prev_q <= '0;
      end
      else
      begin
         latch_q <= latch_d;
         live_prev_q <= live_q;
      end
   end

   // ==========================================================
   // pulse generator for modes 2 and 3
   wire logic any_latched = |unmasked_latch;
   wire logic any_live = |(live_q & ~EVENT_MASK);
   wire logic any_rise = |(rise & ~EVENT_MASK);
   wire logic pg_start = (irq_mode == EVT_REPEAT) ? any_latched :
                         (irq_mode == EVT_SINGLE) ? any_rise : 1'b0;
   wire logic pg_pulse_end = (pg_cnt_q == 32'(PULSE_CYCLES - 1));
   wire logic pg_period_end = (pg_cnt_q == 32'(PERIOD_CYCLES - 1));

   // high phase, then the low rest of the period in mode 2, or back to idle in mode 3
   always_comb
   begin
      pg_state_d = pg_state_q;
      pg_cnt_d = pg_cnt_q + 32'h1;
      case (pg_state_q)
         PG_IDLE:
         begin
            pg_cnt_d = 32'h0;
            if (pg_start)
               pg_state_d = PG_HIGH;
         end
         PG_HIGH:
         begin
            if (pg_pulse_end)
               pg_state_d = (irq_mode == EVT_REPEAT) ? PG_LOW : PG_IDLE;
         end
         PG_LOW:
         begin
            if (pg_period_end)
            begin
               pg_cnt_d = 32'h0;
               pg_state_d = any_latched ? PG_HIGH : PG_IDLE;
            end
         end
         default:
         begin
            pg_state_d = PG_IDLE;
            pg_cnt_d = 32'h0;
         end
      endcase
   end

   // pulse generator state
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         pg_state_q <= PG_IDLE;
         pg_cnt_q <= 32'h0;
      end
      else
      begin
         pg_state_q <= pg_state_d;
         pg_cnt_q <= pg_cnt_d;
      end
   end

   // ==========================================================
   // interrupt pin
   logic irq_act;
   logic irq_q;

   // select the active condition by mode
   always_comb
   begin
      case (irq_mode)
         EVT_LATCHED: irq_act = any_latched;
         EVT_LIVE: irq_act = any_live;
         EVT_REPEAT: irq_act = (pg_state_q == PG_HIGH) && any_latched;
         EVT_SINGLE: irq_act = (pg_state_q == PG_HIGH);
         default: irq_act = 1'b0;
      endcase
   end

   // registered pin with polarity applied
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         irq_q <= 1'b1;
      else
         irq_q <= irq_polarity ? irq_act : ~irq_act;
   end
   assign IRQ_PIN = irq_q;

   // ==========================================================
   // fault power-down
   logic [NOUT-1:0] out_fault;
   wire logic [NOUT-1:0] guard_used =
      out_guard_q & ~(OUT_POWERING_UP & {NOUT{guard_fault_ignore_on_powerup}});
   assign out_fault = out_fault_detect_off ? '0 : (guard_used | out_short_q);
   assign REG_SHORT_FAULT = reg_short_q & ~regulator_short_detect_off;

   // input channels and microphone bias
   fault_powerdown #(
      .CH(NIN)
   ) u_in_pd (
      .clk(CLK_SYS),
      .rst(RST),
      .policy(chan_fault_powerdown_policy),
      .manual_rcv(chan_fault_recovery_mode),
      .fault(IN_FAULT),
      .mask(IN_FAULT_MASK),
      .release_req(IN_RELEASE),
      .pd(IN_POWER_DOWN)
   );

   // output converter channels
   fault_powerdown #(
      .CH(NOUT)
   ) u_out_pd (
      .clk(CLK_SYS),
      .rst(RST),
      .policy(out_fault_powerdown_policy),
      .manual_rcv(out_fault_recovery_mode),
      .fault(out_fault),
      .mask(OUT_FAULT_MASK),
      .release_req(OUT_RELEASE),
      .pd(OUT_POWER_DOWN)
   );

   wire logic out_fault_powered_down_flag = |OUT_POWER_DOWN;

   // ==========================================================
   // read mux, registered
   logic [7:0] rdata_q;
   wire logic [7:0] rd_mux =
      (REG_ADDR == `ADDR_RATIO_HIGH) ? {2'h0, ratio_q[13:8]} :
      (REG_ADDR == `ADDR_RATIO_LOW) ? ratio_q[7:0] :
      (REG_ADDR == `ADDR_INT_CFG) ? int_cfg_q :
      (REG_ADDR == `ADDR_OUT_FLT_CFG) ?
         {1'b0, out_cfg_q[6:4], out_fault_powered_down_flag, out_cfg_q[2:0]} : 8'h00;

   // capture read data
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         rdata_q <= 8'h00;
      else if (REG_RD)
         rdata_q <= rd_mux;
   end
   assign REG_RDATA = rdata_q;
endmodule

/* bench/fault_interrupt_control_chk.sv */
// port assertions for the fault and interrupt control block
`timescale 1ns/1ps
module fault_interrupt_control_chk #(
   parameter int NEV = 8,
   parameter int PULSE_CYCLES = 4
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   // events, ratio, short flag and pin
   input wire logic [NEV-1:0] LATCH_RDATA,
   input wire logic [NEV-1:0] EVENT_LIVE,
   input wire logic [NEV-1:0] EVENT_MASK,
   input wire logic [13:0] FRAME_CLOCK_RATIO,
   input wire logic REG_SHORT_RAW,
   input wire logic REG_SHORT_FAULT,
   input wire logic IRQ_PIN
);
   // ==========================================
   // shadow state
   logic [7:0] cfg_q;
   logic off_q;
   int run_q;
   logic pol_q;
   // pin at its active level (polarity delayed like the pin), latched mode with filter on
   wire irq_on = IRQ_PIN ~^ pol_q;
   wire any_w = |LATCH_RDATA;
   wire lmode = cfg_q[6:5] == 2'h0 && cfg_q[2];
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // copies of written config, length of the active run
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         cfg_q <= 8'h00;
         off_q <= 1'b0;
         run_q <= 0;
         pol_q <= 1'b0;
      end
      else
      begin
         if (REG_WR && REG_ADDR == 8'h42)
            cfg_q <= REG_WDATA;
         if (REG_WR && REG_ADDR == 8'h43)
            off_q <= REG_WDATA[0];
         run_q <= irq_on ? run_q + 1 : 0;
         pol_q <= cfg_q[7];
      end
   end
   a_ratio_low: assert property (
      $stable(FRAME_CLOCK_RATIO)[*4] ##0 (REG_RD && REG_ADDR == 8'h41)
      |=> REG_RDATA == FRAME_CLOCK_RATIO[7:0]) else $error("ratio low byte wrong");
   a_ratio_high: assert property (
      $stable(FRAME_CLOCK_RATIO)[*4] ##0 (REG_RD && REG_ADDR == 8'h40)
      |=> REG_RDATA == {2'h0, FRAME_CLOCK_RATIO[13:8]}) else $error("ratio high wrong");
   a_unmapped_zero: assert property (
      REG_RD && REG_ADDR > 8'h43 |=> REG_RDATA == 8'h00) else $error("unmapped not zero");
   a_rdata_hold: assert property (
      !REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
   a_short_gate: assert property (
      !$past(RST) && !$past(RST, 2) |-> REG_SHORT_FAULT == ($past(REG_SHORT_RAW, 2) && !off_q))
      else $error("regulator short flag wrong");
   a_latched_mode: assert property (
      $past(lmode) |-> IRQ_PIN == ($past(cfg_q[7]) ~^ $past(any_w)))
      else $error("latched mode pin wrong");
   a_live_mode: assert property (
      (cfg_q[6:5] == 2'h1 && $stable(cfg_q) && $stable(EVENT_LIVE) && $stable(EVENT_MASK))[*5]
      |-> IRQ_PIN == (cfg_q[7] ~^ |(EVENT_LIVE & ~EVENT_MASK))) else $error("live mode pin wrong");
   a_single_pulse: assert property (
      $fell(irq_on) && cfg_q[6:5] == 2'h3 && $stable(cfg_q) |-> run_q == PULSE_CYCLES)
      else $error("single pulse length wrong");
endmodule
bind fault_interrupt_control fault_interrupt_control_chk
   #(.NEV(NEV), .PULSE_CYCLES(PULSE_CYCLES)) chk_i (.CLK_SYS, .RST, .REG_ADDR,
   .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .LATCH_RDATA, .EVENT_LIVE,
   .EVENT_MASK, .FRAME_CLOCK_RATIO, .REG_SHORT_RAW, .REG_SHORT_FAULT, .IRQ_PIN);

/* bench/fault_host_model.sv */
// host model driving register and latch read strobes
`timescale 1ns/1ps
module fault_host_model
(
   // clock and read data
   input wire logic clk,
   input wire logic [7:0] rdata,
   // strobes, address and data
   output logic [7:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata,
   output logic lrd
);
   // ==========================================
   // bus cycles
   initial {addr, wr, rd, wdata, lrd} = '0;
   // one-cycle strobe, changed just after the edge
   task automatic pulse(input logic [2:0] k);
      @(posedge clk);
      #1;
      {wr, rd, lrd} = k;
      @(posedge clk);
      #1;
      {wr, rd, lrd} = 3'h0;
   endtask
   // data is driven as given; callers may set reserved bits
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      pulse(3'h4);
   endtask
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      addr = a;
      pulse(3'h2);
      d = rdata;
   endtask
endmodule

/* bench/fault_interrupt_control_test.sv */
// self-checking bench for the fault and interrupt control block
`timescale 1ns/1ps
module fault_interrupt_control_test;
   logic clk, rst, lrd, wr, rd, rsr, sf, irq;
   logic [7:0] addr, wd, rdat, lat, ev, evm, d;
   logic [13:0] ratio;
   logic [3:0] inf, inm, inr, inpd;
   logic [1:0] og, os, opu, om, orl, opd;
   int n_errors, checked, cnt;
   fault_host_model h (.clk(clk), .rdata(rdat), .addr(addr), .wr(wr), .rd(rd),
      .wdata(wd), .lrd(lrd));
   fault_interrupt_control #(.PULSE_CYCLES(4), .PERIOD_CYCLES(8)) uut (
      .CLK_SYS(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
      .REG_WDATA(wd), .REG_RDATA(rdat), .LATCH_RD(lrd), .LATCH_RDATA(lat),
      .EVENT_LIVE(ev), .EVENT_MASK(evm), .FRAME_CLOCK_RATIO(ratio),
      .IN_FAULT(inf), .IN_FAULT_MASK(inm), .IN_RELEASE(inr), .IN_POWER_DOWN(inpd),
      .OUT_GUARD_FAULT(og), .OUT_SHORT_FAULT(os), .OUT_POWERING_UP(opu),
      .OUT_FAULT_MASK(om), .OUT_RELEASE(orl), .OUT_POWER_DOWN(opd),
      .REG_SHORT_RAW(rsr), .REG_SHORT_FAULT(sf), .IRQ_PIN(irq));
   // ==========================================
   // helpers
   initial
   begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      checked++;
      if (a !== e)
         $display("[ERR] %0t got %h want %h", $time, a, e);
      if (a !== e)
         n_errors++;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      h.rd8(a, d);
      chk(d, e);
   endtask
   // count cycles with the low-active pin asserted
   task automatic lowc(input int n);
      cnt = 0;
      repeat (n)
      begin
         cyc(1);
         cnt += (irq === 1'b0);
      end
   endtask
   task automatic t_regs;
      rchk(8'h42, 8'h00);
      rchk(8'h43, 8'h54);
      rchk(8'h40, 8'h2A);
      h.wr8(8'h41, 8'h00);
      rchk(8'h41, 8'h5C);
      rchk(8'h50, 8'h00);
      h.wr8(8'h43, 8'h7F);
      rchk(8'h43, 8'h77);
      h.wr8(8'h43, 8'h54);
      $display("t_regs done");
   endtask
   task automatic t_events;
      ev = 8'h01;
      cyc(1);
      ev = 8'h00;
      cyc(5);
      chk({lat[6:0], irq}, 8'h02);
      ev = 8'h01;
      cyc(5);
      h.pulse(3'h1);
      chk(lat, 8'h01);
      ev = 8'h00;
      cyc(4);
      h.pulse(3'h1);
      cyc(1);
      chk({lat[6:0], irq}, 8'h01);
      h.wr8(8'h42, 8'h05);
      ev = 8'h01;
      cyc(5);
      evm = 8'h01;
      cyc(1);
      chk(lat, 8'h00);
      evm = 8'h00;
      h.wr8(8'h42, 8'h85);
      cyc(1);
      chk({lat[6:0], irq}, 8'h03);
      h.pulse(3'h1);
      chk(lat, 8'h00);
      ev = 8'h00;
      h.wr8(8'h42, 8'h60);
      ev = 8'h02;
      cyc(1);
      ev = 8'h00;
      lowc(20);
      chk(8'(cnt), 8'h04);
      h.wr8(8'h42, 8'h40);
      cyc(10);
      lowc(16);
      chk(8'(cnt), 8'h08);
      h.wr8(8'h42, 8'h20);
      ev = 8'h04;
      cyc(6);
      chk({7'h0, irq}, 8'h00);
      ev = 8'h00;
      cyc(6);
      chk({7'h0, irq}, 8'h01);
      $display("t_events done");
   endtask
   task automatic t_inpd;
      for (int p = 0; p < 4; p++)
         for (int m = 0; m < 2; m++)
         begin
            h.wr8(8'h42, 8'(p << 3));
            inm = 4'(m);
            inf = 4'h1;
            cyc(2);
            chk({4'h0, inpd}, {7'h0, p == 2 || (p == 1 && m == 0)});
            inf = 4'h0;
            cyc(2);
            chk({4'h0, inpd}, 8'h00);
         end
      h.wr8(8'h42, 8'h12);
      inf = 4'h1;
      cyc(2);
      inf = 4'h0;
      cyc(3);
      chk({4'h0, inpd}, 8'h01);
      inr = 4'h1;
      cyc(1);
      inr = 4'h0;
      cyc(1);
      chk({4'h0, inpd}, 8'h00);
      $display("t_inpd done");
   endtask
   task automatic t_outpd;
      os = 2'h1;
      cyc(4);
      rchk(8'h43, 8'h5C);
      os = 2'h0;
      cyc(4);
      chk({6'h0, opd}, 8'h01);
      orl = 2'h1;
      cyc(1);
      orl = 2'h0;
      cyc(1);
      rchk(8'h43, 8'h54);
      {opu, og} = 4'h5;
      cyc(4);
      chk({6'h0, opd}, 8'h00);
      h.wr8(8'h43, 8'h40);
      cyc(2);
      chk({6'h0, opd}, 8'h01);
      {opu, og} = 4'h0;
      h.wr8(8'h43, 8'h02);
      os = 2'h2;
      h.wr8(8'h43, 8'h42);
      cyc(4);
      chk({6'h0, opd}, 8'h00);
      h.wr8(8'h43, 8'h40);
      cyc(3);
      chk({6'h0, opd}, 8'h02);
      os = 2'h0;
      rsr = 1'b1;
      cyc(4);
      chk({5'h0, opd, sf}, 8'h01);
      h.wr8(8'h43, 8'h41);
      chk({7'h0, sf}, 8'h00);
      h.wr8(8'h43, 8'h20);
      om = 2'h1;
      os = 2'h3;
      cyc(4);
      chk({6'h0, opd}, 8'h02);
      os = 2'h0;
      om = 2'h0;
      $display("t_outpd done");
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ==========================================
   // main sequence and watchdog
   initial
   begin
      {ev, evm, inf, inm, inr, og, os, opu, om, orl, rsr} = '0;
      {n_errors, checked} = '0;
      ratio = 14'h2A5C;
      rst = 1'b1;
      cyc(10);
      rst = 1'b0;
      t_regs;
      t_events;
      t_inpd;
      t_outpd;
      final_report;
   end
   initial
   begin
      #40000;
      n_errors++;
      final_report;
   end
endmodule
